// [rtl/pdt_pkg.sv]
package pdt_pkg;
	// ==========================================
	// Timing
	localparam int CORE_HZ      = 20000000;
	localparam int LS_HZ_MILLI  = 32768000;
	// Phase accumulator for 32.768 kHz from core clock
	localparam int LS_ACC_W     = 24;
	localparam logic [LS_ACC_W-1:0] LS_ACC_INC =
		LS_ACC_W'((64'(LS_HZ_MILLI) << LS_ACC_W) / (64'(CORE_HZ) * 64'd1000));
	localparam int CMP_W        = 16;
	localparam int DIV_W        = 8;
	localparam logic [CMP_W-1:0] CMP_RESET = 16'hffff;
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h05;
	// ==========================================
	// Sequencer
	typedef enum logic [1:0] {
		PDT_CMD_NONE,
		PDT_CMD_CHAN_DIS,
		PDT_CMD_STANDBY,
		PDT_CMD_WAKE
	} pdt_cmd_t;
	typedef enum logic [1:0] {
		PDT_CH_ALL,
		PDT_CH_DETECT
	} pdt_chcfg_t;
endpackage : pdt_pkg

// [rtl/pdt_ready_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module pdt_ready_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      level,
	output logic      fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} pdt_sync_t;
	pdt_sync_t r, next_r;
	// ==========================================
	// Two stages, then edge detect on stage two
	always_comb begin
		next_r    = r;
		next_r.s1 = async_in;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end
	assign level = r.s2;
	assign fall  = r.s3 & ~r.s2;
endmodule : pdt_ready_sync
`default_nettype wire

// [rtl/pdt_trigger_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module pdt_trigger_timer
	import pdt_pkg::*;
#(
	parameter int CW = CMP_W,
	parameter int DW = DIV_W
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          tick,
	input  wire logic          run,
	input  wire logic          preload,
	input  wire logic [CW-1:0] period_compare_value,
	input  wire logic [CW-1:0] pulse_compare_value,
	input  wire logic [DW-1:0] divider,
	output logic               out_pin,
	output logic [CW-1:0]      count
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic [DW-1:0] div;
		logic          out;
	} pdt_tmr_t;
	pdt_tmr_t r, next_r;
	logic     step;
	// ==========================================
	// Divided tick, up mode, reset/set output
	always_comb begin
		next_r = r;
		step   = 1'b0;
		if (preload) begin
			next_r.cnt = pulse_compare_value;
			next_r.div = '0;
			// Loaded count already sits on the pulse match, so the pin drops at once unless pulse exceeds period
			next_r.out = (pulse_compare_value > period_compare_value);
		end else if (run && tick) begin
			if (r.div + DW'(1) >= divider || divider == '0) begin
				next_r.div = '0;
				step       = 1'b1;
			end else begin
				next_r.div = r.div + DW'(1);
			end
		end
		if (step) begin
			if (r.cnt >= period_compare_value) begin
				next_r.cnt = '0;
			end else begin
				next_r.cnt = r.cnt + CW'(1);
			end
			// Low while the count sits in pulse..period gives period+1-pulse ticks
			if (next_r.cnt == pulse_compare_value) begin
				next_r.out = 1'b0;
			end else if (next_r.cnt == '0) begin
				next_r.out = 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '{cnt: '0, div: '0, out: 1'b1};
		end else begin
			r <= next_r;
		end
	end
	assign out_pin = r.out;
	assign count   = r.cnt;
endmodule : pdt_trigger_timer
`default_nettype wire

// [rtl/pdt_detect_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module pdt_detect_ctrl
	import pdt_pkg::*;
(
	input  wire logic                 CORE_CLK,
	input  wire logic                 RST,
	input  wire logic                 ENTER,
	input  wire logic                 EXIT,
	input  wire logic [CMP_W-1:0]     PERIOD_COMPARE_VALUE,
	input  wire logic [CMP_W-1:0]     PULSE_COMPARE_VALUE,
	input  wire logic [DIV_W-1:0]     DIVIDER,
	input  wire logic                 CMD_DONE,
	input  wire logic                 CONVERSION_READY_FLAG_N,
	output pdt_pkg::pdt_cmd_t         CMD,
	output pdt_pkg::pdt_chcfg_t       CMD_CHCFG,
	output logic                      CMD_VALID,
	output logic                      TRIG_RESET_N,
	output logic                      CONVERTER_CLOCK_INPUT,
	output logic                      READY_IRQ_EN,
	output logic                      DETECT_ACTIVE,
	output logic                      TAMPER_IRQ,
	output logic                      SAMPLE_IRQ,
	output logic                      BUSY
);
	import pdt_pkg::*;
	typedef enum {
		ST_NORMAL,
		ST_EN_CHDIS,
		ST_EN_STBY,
		ST_EN_START,
		ST_DETECT,
		ST_EX_STOP,
		ST_EX_WAKE,
		ST_EX_CHEN
	} pdt_state_t;
	typedef struct packed {
		pdt_state_t          st;
		logic                timer_pin;
		logic                clk_on;
		logic                irq_en;
		logic                run;
		logic                clkdiv;
		logic [LS_ACC_W-1:0] acc;
		logic                tick;
		logic                tamper;
		logic                sample;
		pdt_cmd_t            cmd;
		pdt_chcfg_t          chcfg;
		logic                cmd_v;
	} pdt_ctl_t;
	pdt_ctl_t r, next_r;
	logic preload;
	logic tmr_out;
	logic rdy_fall;
	logic [LS_ACC_W:0] acc_sum;
	// ==========================================
	// Ready input crossing
	pdt_ready_sync u_sync (
		.clk      (CORE_CLK),
		.rst      (RST),
		.async_in (CONVERSION_READY_FLAG_N),
		.level    (),
		.fall     (rdy_fall)
	);
	// ==========================================
	// Trigger timer
	pdt_trigger_timer u_tmr (
		.clk                  (CORE_CLK),
		.rst                  (RST),
		.tick                 (r.tick),
		.run                  (r.run),
		.preload              (preload),
		.period_compare_value (PERIOD_COMPARE_VALUE),
		.pulse_compare_value  (PULSE_COMPARE_VALUE),
		.divider              (DIVIDER),
		.out_pin              (tmr_out),
		.count                ()
	);
	// ==========================================
	// Sequencer
	always_comb begin
		next_r  = r;
		preload = 1'b0;
		// Low-speed tick keeps timing independent of the converter clock
		acc_sum = {1'b0, r.acc} + {1'b0, LS_ACC_INC};
		next_r.acc  = acc_sum[LS_ACC_W-1:0];
		next_r.tick = acc_sum[LS_ACC_W];
		// Core clock halved, mirroring the crystal divide by two
		next_r.clkdiv = r.clk_on ? ~r.clkdiv : 1'b0;
		next_r.tamper = 1'b0;
		next_r.sample = 1'b0;
		if (rdy_fall && r.irq_en) begin
			if (r.st == ST_DETECT) begin
				next_r.tamper = 1'b1;
			end else begin
				next_r.sample = 1'b1;
			end
		end
		if (r.cmd_v && CMD_DONE) begin
			next_r.cmd_v = 1'b0;
		end
		case (r.st)
			ST_NORMAL: begin
				if (ENTER) begin
					next_r.irq_en = 1'b0;
					next_r.cmd    = PDT_CMD_CHAN_DIS;
					next_r.chcfg  = PDT_CH_DETECT;
					next_r.cmd_v  = 1'b1;
					next_r.st     = ST_EN_CHDIS;
				end
			end
			ST_EN_CHDIS: begin
				if (r.cmd_v && CMD_DONE) begin
					next_r.cmd   = PDT_CMD_STANDBY;
					next_r.cmd_v = 1'b1;
					next_r.st    = ST_EN_STBY;
				end
			end
			ST_EN_STBY: begin
				if (r.cmd_v && CMD_DONE) begin
					// Load with the pin switch so a stale timer level never shows
					preload          = 1'b1;
					next_r.timer_pin = 1'b1;
					next_r.clk_on    = 1'b0;
					next_r.st        = ST_EN_START;
				end
			end
			ST_EN_START: begin
				next_r.run    = 1'b1;
				next_r.irq_en = 1'b1;
				next_r.st     = ST_DETECT;
			end
			ST_DETECT: begin
				if (EXIT) begin
					next_r.run    = 1'b0;
					next_r.irq_en = 1'b0;
					next_r.st     = ST_EX_STOP;
				end
			end
			ST_EX_STOP: begin
				next_r.timer_pin = 1'b0;
				next_r.clk_on    = 1'b1;
				next_r.cmd       = PDT_CMD_WAKE;
				next_r.cmd_v     = 1'b1;
				next_r.st        = ST_EX_WAKE;
			end
			ST_EX_WAKE: begin
				if (r.cmd_v && CMD_DONE) begin
					next_r.cmd   = PDT_CMD_CHAN_DIS;
					next_r.chcfg = PDT_CH_ALL;
					next_r.cmd_v = 1'b1;
					next_r.st    = ST_EX_CHEN;
				end
			end
			ST_EX_CHEN: begin
				if (r.cmd_v && CMD_DONE) begin
					next_r.irq_en = 1'b1;
					next_r.cmd    = PDT_CMD_NONE;
					next_r.st     = ST_NORMAL;
				end
			end
			default: begin
				next_r.st = ST_NORMAL;
			end
		endcase
	end
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			r <= '{st: ST_NORMAL, timer_pin: 1'b0, clk_on: 1'b1, irq_en: 1'b1,
				run: 1'b0, clkdiv: 1'b0, acc: '0, tick: 1'b0, tamper: 1'b0,
				sample: 1'b0, cmd: PDT_CMD_NONE, chcfg: PDT_CH_ALL, cmd_v: 1'b0};
		end else begin
			r <= next_r;
		end
	end
	// ==========================================
	// Outputs; GPIO mode holds the pin high
	assign TRIG_RESET_N          = r.timer_pin ? tmr_out : 1'b1;
	assign CONVERTER_CLOCK_INPUT = r.clkdiv;
	assign CMD                   = r.cmd;
	assign CMD_CHCFG             = r.chcfg;
	assign CMD_VALID             = r.cmd_v;
	assign READY_IRQ_EN          = r.irq_en;
	assign DETECT_ACTIVE         = (r.st == ST_DETECT);
	assign TAMPER_IRQ            = r.tamper;
	assign SAMPLE_IRQ            = r.sample;
	assign BUSY                  = (r.st != ST_NORMAL) && (r.st != ST_DETECT);
endmodule : pdt_detect_ctrl
`default_nettype wire

// [bench/pdt_chk_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module pdt_chk
	import pdt_pkg::*;
(
	input wire logic             CORE_CLK,
	input wire logic             RST,
	input wire logic             ENTER,
	input wire logic             EXIT,
	input wire logic [DIV_W-1:0] DIVIDER,
	input wire logic             CMD_DONE,
	input wire logic             CONVERSION_READY_FLAG_N,
	input wire pdt_pkg::pdt_cmd_t CMD,
	input wire logic             CMD_VALID,
	input wire logic             TRIG_RESET_N,
	input wire logic             CONVERTER_CLOCK_INPUT,
	input wire logic             READY_IRQ_EN,
	input wire logic             DETECT_ACTIVE,
	input wire logic             TAMPER_IRQ,
	input wire logic             SAMPLE_IRQ,
	input wire logic             BUSY
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	wire idle = !BUSY && !DETECT_ACTIVE;
	// ==========================================
	// Steps
	sequence s_stby_done;
		CMD_VALID && CMD_DONE && CMD == PDT_CMD_STANDBY;
	endsequence
	sequence s_rdy_fall;
		$fell(CONVERSION_READY_FLAG_N) && DETECT_ACTIVE && READY_IRQ_EN;
	endsequence
	// ==========================================
	// Checks
	chk_idle_pin: assert property (idle |-> TRIG_RESET_N)
		else $error("trigger pin low while idle");
	chk_clk_stop: assert property (DETECT_ACTIVE |-> !CONVERTER_CLOCK_INPUT)
		else $error("converter clock runs in detect");
	chk_clk_run: assert property (idle [*2] |-> !$stable(CONVERTER_CLOCK_INPUT))
		else $error("converter clock stalled");
	chk_mask_cmd: assert property (CMD_VALID |-> !READY_IRQ_EN)
		else $error("ready irq enabled during command");
	chk_cmd_hold: assert property (CMD_VALID && !CMD_DONE |=> CMD_VALID && $stable(CMD))
		else $error("command dropped early");
	chk_enter_ack: assert property (ENTER && idle |=> CMD_VALID && CMD == PDT_CMD_CHAN_DIS)
		else $error("entry did not start with channel config");
	chk_stby_arm: assert property (s_stby_done |-> ##2 DETECT_ACTIVE && READY_IRQ_EN)
		else $error("detect not armed after standby");
	chk_first_pulse: assert property ($rose(DETECT_ACTIVE) && DIVIDER <= 8'h01 |-> ##[0:700] !TRIG_RESET_N)
		else $error("first trigger late");
	chk_tamper_irq: assert property (s_rdy_fall |-> ##[1:4] TAMPER_IRQ)
		else $error("tamper irq missing");
	chk_tamper_one: assert property (TAMPER_IRQ |->
		$past(DETECT_ACTIVE) && !SAMPLE_IRQ ##1 !TAMPER_IRQ)
		else $error("tamper irq malformed");
	chk_exit_wake: assert property (EXIT && DETECT_ACTIVE |-> ##[1:3] CMD_VALID && CMD == PDT_CMD_WAKE && TRIG_RESET_N)
		else $error("exit did not wake converter");
endmodule // pdt_chk
bind pdt_detect_ctrl pdt_chk u_chk (.*);
`default_nettype wire

// [bench/pdt_conv_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pdt_conv_model
	import pdt_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [1:0]        slow,
	input  wire logic              tamper,
	input  wire pdt_pkg::pdt_cmd_t cmd,
	input  wire logic              cmd_valid,
	input  wire logic              trig_n,
	input  wire logic              conv_clk,
	output logic                   cmd_done,
	output logic                   rdy_n
);
	logic [1:0] mode;
	logic [1:0] wcnt;
	logic [6:0] cnt;
	logic       trig_q;
	logic       ck_q;
	initial begin
		cmd_done = 1'b0;
		rdy_n = 1'b1;
	end
	// ==========================================
	// Mode 0 converting, 1 standby, 2 detect
	always @(posedge clk) begin
		trig_q <= trig_n;
		ck_q <= conv_clk;
		cmd_done <= 1'b0;
		rdy_n <= 1'b1;
		if (rst) begin
			mode <= 2'd0;
			wcnt <= 2'd0;
			cnt <= 7'h00;
		end else begin
			if (cmd_valid && !cmd_done) begin
				wcnt <= wcnt + 2'd1;
				if (wcnt >= slow) begin
					cmd_done <= 1'b1;
					wcnt <= 2'd0;
					if (cmd == PDT_CMD_STANDBY) mode <= 2'd1;
					if (cmd == PDT_CMD_WAKE) mode <= 2'd0;
				end
			end
			case (mode)
			2'd0: if (conv_clk && !ck_q) begin
				cnt <= cnt + 7'h01;
				rdy_n <= cnt != 7'h00;
			end
			2'd1: if (trig_q && !trig_n) begin
				mode <= 2'd2;
				cnt <= 7'h00;
			end
			default: begin
				cnt <= cnt + 7'h01;
				if (tamper && cnt == 7'h0a) begin
					rdy_n <= 1'b0;
					mode <= 2'd1;
				end
				if (cnt == 7'h64) mode <= 2'd1;
			end
			endcase
		end
	end
endmodule // pdt_conv_model
`default_nettype wire

// [bench/pdt_detect_ctrl_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module pdt_detect_ctrl_tb_top;
	import pdt_pkg::*;
	logic CORE_CLK = 0, RST = 1, ENTER = 0, EXIT = 0, CMD_DONE, CONVERSION_READY_FLAG_N;
	logic [CMP_W-1:0] PERIOD_COMPARE_VALUE = 16'h0003, PULSE_COMPARE_VALUE = 16'h0002;
	logic [DIV_W-1:0] DIVIDER = 8'h01;
	pdt_cmd_t CMD;
	pdt_chcfg_t CMD_CHCFG;
	logic CMD_VALID, TRIG_RESET_N, CONVERTER_CLOCK_INPUT, READY_IRQ_EN;
	logic DETECT_ACTIVE, TAMPER_IRQ, SAMPLE_IRQ, BUSY, tamper = 0;
	logic [1:0] slow = 2'b00;
	logic [7:0] w, notes[$];
	int bad_count = 0, n_checks = 0, i, t0, p, q, d, e;
	pdt_detect_ctrl dut (.*);
	pdt_conv_model u_conv (.clk(CORE_CLK), .rst(RST), .slow(slow), .tamper(tamper),
		.cmd(CMD), .cmd_valid(CMD_VALID), .trig_n(TRIG_RESET_N), .conv_clk(CONVERTER_CLOCK_INPUT),
		.cmd_done(CMD_DONE), .rdy_n(CONVERSION_READY_FLAG_N));
	always #25 CORE_CLK = ~CORE_CLK;
	// ==========================================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	function automatic logic cond(input int k);
		case (k)
		0: return DETECT_ACTIVE;
		1: return !TRIG_RESET_N;
		2: return TRIG_RESET_N;
		3: return TAMPER_IRQ;
		4: return !BUSY && !DETECT_ACTIVE;
		default: return SAMPLE_IRQ;
		endcase
	endfunction
	task automatic wfor(input int k, input int lim);
		t0 = 0;
		while (cond(k) !== 1'b1 && t0 < lim) begin
			@(posedge CORE_CLK);
			#1;
			t0++;
		end
	endtask
	task automatic in_tol(input int exp); // Tick jitter of one core cycle per edge
		check(t0 + 3 >= exp && t0 <= exp + 3, 1);
	endtask
	// ==========================================
	// Monitor of commands and tamper events
	always @(posedge CORE_CLK) begin
		if (!RST && ((CMD_VALID && CMD_DONE) || TAMPER_IRQ)) begin
			w = TAMPER_IRQ ? 8'h80 : {4'h1, CMD, CMD == PDT_CMD_CHAN_DIS ? CMD_CHCFG : 2'b00};
			if (notes.size() == 0) check(w, 32'hff);
			else check(w, notes.pop_front());
		end
	end
	initial begin
		#4500000;
		bad_count++;
		results();
	end
	// ==========================================
	// Tests
	initial begin
		void'($urandom(20));
		repeat (4) @(posedge CORE_CLK);
		RST <= 0;
		#1;
		check(TRIG_RESET_N, 1);
		check(READY_IRQ_EN, 1);
		@(posedge CORE_CLK) EXIT <= 1;
		@(posedge CORE_CLK) EXIT <= 0;
		wfor(5, 2000);
		check(SAMPLE_IRQ, 1);
		for (i = 0; i < 2; i++) begin
			p = $urandom_range(5, 2);
			q = $urandom_range(p, 1);
			d = i * 2;
			e = (d == 0) ? 1 : d;
			@(posedge CORE_CLK);
			PERIOD_COMPARE_VALUE <= 16'(p);
			PULSE_COMPARE_VALUE <= 16'(q);
			DIVIDER <= 8'(d);
			slow <= 2'(i * 3);
			notes.push_back({4'h1, PDT_CMD_CHAN_DIS, PDT_CH_DETECT});
			notes.push_back({4'h1, PDT_CMD_STANDBY, 2'b00});
			ENTER <= 1;
			@(posedge CORE_CLK) ENTER <= 0;
			wfor(0, 100);
			check(DETECT_ACTIVE, 1);
			wfor(1, 1400);
			check(t0 <= e * 611 + 3, 1);
			@(posedge CORE_CLK) ENTER <= 1;
			@(posedge CORE_CLK) ENTER <= 0;
			wfor(2, 20000);
			wfor(1, 20000);
			wfor(2, 20000);
			in_tol(((p + 1 - q) * e * 625000) / 1024);
			wfor(1, 20000);
			in_tol((q * e * 625000) / 1024);
			tamper <= 1;
			notes.push_back(8'h80);
			wfor(3, 20000);
			@(posedge CORE_CLK) tamper <= 0;
			notes.push_back({4'h1, PDT_CMD_WAKE, 2'b00});
			notes.push_back({4'h1, PDT_CMD_CHAN_DIS, PDT_CH_ALL});
			EXIT <= 1;
			@(posedge CORE_CLK) EXIT <= 0;
			wfor(4, 100);
			check(TRIG_RESET_N, 1);
			check(READY_IRQ_EN, 1);
			wfor(5, 2000);
			check(SAMPLE_IRQ, 1);
			check(notes.size(), 0);
			$display("test %0d done", i);
		end
		results();
	end
endmodule // pdt_detect_ctrl_tb_top
`default_nettype wire
